/* hw/ecl_pkg.sv */
// ecl_pkg: constants, types and field layouts of the config image loader
// assumes a 25 MHz core clock and an open-drain two-wire bus with pull-ups
package ecl_pkg;

    // bus timing: one quarter of a bit cell, least time rounds up
    localparam int QUARTER_NS  = 2500;
    localparam int CLK_MHZ     = 25;
    localparam int QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;

    // serial memory target address bytes
    localparam logic [7:0] MEM_WR_BYTE = 8'hA0;
    localparam logic [7:0] MEM_RD_BYTE = 8'hA1;

    // header byte 0 layout
    localparam int HDR_CRC_EN_BIT = 7;
    localparam int HDR_MAP_BIT    = 6;
    localparam int HDR_WIDE_BIT   = 5;

    // image layout
    localparam logic [5:0]  HDR_LEN     = 6'h03;
    localparam logic [15:0] TABLE_BASE  = 16'h0003;
    localparam logic [15:0] BLOCK_BASE  = 16'h0003;
    localparam logic [5:0]  DATA_LEN    = 6'h25;
    localparam logic [5:0]  HDR_IDX_BST = 6'h02;

    // crc-8, x^8+x^2+x+1
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // values after reset
    localparam logic [7:0] REG01_RESET = 8'h00;

    typedef struct packed {
        logic signal_absent_override;
        logic signal_absent_forced_value;
        logic input_power_down;
        logic oscillator_power_down;
        logic ext_serial_ata_mode_a;
        logic ext_serial_ata_mode_b;
        logic transmit_off_override;
        logic transmit_off_a;
        logic transmit_off_b;
        logic fourth_boost_stage_b;
        logic fourth_boost_stage_a;
        logic quiet_threshold_override;
        logic channel_b_power_down;
        logic channel_a_power_down;
    } ecl_cfg_t;

    localparam ecl_cfg_t CFG_RESET = '0;

    typedef enum {
        M_WAIT, M_HDR, M_TAB, M_DATA, M_CRCB, M_CHECK, M_DONE
    } ecl_main_state_t;

endpackage : ecl_pkg

/* hw/ecl_twi_reader.sv */
// ecl_twi_reader: two-wire master doing one random burst read per command
// assumes sda_sync is already synchronised; open-drain pins, oe high = pull low
`timescale 1ns/1ps
module ecl_twi_reader #(parameter int QUARTER = ecl_pkg::QUARTER_CYC) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_go,
    input  wire logic [15:0] cmd_addr,
    input  wire logic        cmd_wide,
    input  wire logic [7:0]  cmd_len,
    input  wire logic        sda_sync,
    output logic             busy,
    output logic             rx_valid,
    output logic [7:0]       rx_data,
    output logic             done,
    output logic             fault,
    output logic             scl_oe,
    output logic             sda_oe
);

    typedef enum {E_IDLE, E_START, E_BIT, E_STOP} ecl_eng_state_t;

    ecl_eng_state_t state;
    logic [1:0]  phase;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic [1:0]  step;
    logic        reading;
    logic [7:0]  left;
    logic [15:0] addr_r;
    logic        wide_r;
    logic [6:0]  qcnt;
    logic        nack;

    function automatic logic [7:0] byte_for(input logic [1:0] s,
                                            input logic [15:0] a);
        unique case (s)
            2'h0: byte_for = ecl_pkg::MEM_WR_BYTE;
            2'h1: byte_for = a[15:8];
            2'h2: byte_for = a[7:0];
            2'h3: byte_for = ecl_pkg::MEM_RD_BYTE;
        endcase
    endfunction : byte_for

    wire       tick      = (state != E_IDLE) &&
                           (qcnt == 7'(QUARTER - 1));
    wire       ack_slot  = (bitn == 4'h8);
    wire [1:0] next_step = (step == 2'h0) ? (wide_r ? 2'h1 : 2'h2) : 2'h2;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state    <= E_IDLE;
            phase    <= 2'h0;
            bitn     <= 4'h0;
            shreg    <= 8'h00;
            step     <= 2'h0;
            reading  <= 1'b0;
            left     <= 8'h00;
            addr_r   <= 16'h0000;
            wide_r   <= 1'b0;
            qcnt     <= 7'h00;
            nack     <= 1'b0;
            busy     <= 1'b0;
            rx_valid <= 1'b0;
            rx_data  <= 8'h00;
            done     <= 1'b0;
            fault    <= 1'b0;
            scl_oe   <= 1'b0;
            sda_oe   <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            done     <= 1'b0;
            if (state == E_IDLE) begin
                if (cmd_go) begin
                    state   <= E_START;
                    step    <= 2'h0;
                    reading <= 1'b0;
                    left    <= cmd_len;
                    addr_r  <= cmd_addr;
                    wide_r  <= cmd_wide;
                    fault   <= 1'b0;
                    phase   <= 2'h0;
                    qcnt    <= 7'h00;
                    busy    <= 1'b1;
                end
            end else begin
                qcnt <= tick ? 7'h00 : qcnt + 7'h01;
                if (tick) begin
                    phase <= phase + 2'h1;
                    unique case (state)
                        E_START: begin
                            unique case (phase)
                                2'h0: sda_oe <= 1'b0;
                                2'h1: scl_oe <= 1'b0;
                                2'h2: sda_oe <= 1'b1;
                                2'h3: begin
                                    scl_oe <= 1'b1;
                                    state  <= E_BIT;
                                    bitn   <= 4'h0;
                                    shreg  <= byte_for(step, addr_r);
                                end
                            endcase
                        end
                        E_BIT: begin
                            unique case (phase)
                                // the last byte of a burst is refused so
                                // the memory lets go of data for the stop
                                2'h0: sda_oe <= reading
                                    ? (ack_slot && left != 8'h01)
                                    : (!ack_slot && !shreg[7]);
                                2'h1: scl_oe <= 1'b0;
                                2'h2: begin
                                    if (reading && !ack_slot)
                                        shreg <= {shreg[6:0], sda_sync};
                                    if (!reading && ack_slot)
                                        nack <= sda_sync;
                                end
                                2'h3: begin
                                    scl_oe <= 1'b1;
                                    if (!ack_slot) begin
                                        bitn <= bitn + 4'h1;
                                        if (!reading)
                                            shreg <= {shreg[6:0], 1'b0};
                                    end else begin
                                        bitn <= 4'h0;
                                        if (reading) begin
                                            rx_valid <= 1'b1;
                                            rx_data  <= shreg;
                                            left     <= left - 8'h01;
                                            if (left == 8'h01)
                                                state <= E_STOP;
                                        end else if (nack) begin
                                            fault <= 1'b1;
                                            state <= E_STOP;
                                        end else if (step == 2'h2) begin
                                            step  <= 2'h3;
                                            state <= E_START;
                                        end else if (step == 2'h3) begin
                                            reading <= 1'b1;
                                        end else begin
                                            step  <= next_step;
                                            shreg <= byte_for(next_step,
                                                              addr_r);
                                        end
                                    end
                                end
                            endcase
                        end
                        E_STOP: begin
                            unique case (phase)
                                2'h0: sda_oe <= 1'b1;
                                2'h1: scl_oe <= 1'b0;
                                2'h2: sda_oe <= 1'b0;
                                2'h3: begin
                                    state <= E_IDLE;
                                    done  <= 1'b1;
                                    busy  <= 1'b0;
                                end
                            endcase
                        end
                        default: state <= E_IDLE;
                    endcase
                end
            end
        end
    end

endmodule : ecl_twi_reader

/* hw/ecl_loader.sv */
// ecl_loader: power-up loader of a repeater's settings from a serial memory
// assumes pins are asynchronous to core_clk; memory answers at 0xA0/0xA1
//
// Summary of operation
// - header byte 0: crc, map, wide, count
// - header byte 1 used only in the crc
// - no burst longer than header byte 2, one byte if it is zero
// - device crc at bytes 3,5,7,9
// - device block start at bytes 4,6,8,10
// - block holds 37 consecutive register bytes
// - first block byte: channel power-downs
// - second block byte: power, sata, tx override
// - byte 3 copied whole into register 0x01
// - byte 4 spread into 0x02 and 0x04
// - byte 4 bit meanings, override to tx
// - byte 5 spread into 0x04, 0x06, 0x08
// - byte 5 bit meanings, tx off to idle
// - crc-8 poly 0x07 over 40 bytes
// - start on permit low, done low after
// - release bus and become slave after
// - no map: start from strap and size
`timescale 1ns/1ps
module ecl_loader #(parameter int QUARTER = ecl_pkg::QUARTER_CYC) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             load_permit_n,
    input  wire logic [3:0]       addr_strap,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  scl_out,
    output logic                  scl_oe,
    output logic                  sda_out,
    output logic                  sda_oe,
    output logic                  load_done_n,
    output logic                  load_busy,
    output logic                  slave_mode,
    output logic                  crc_fail,
    output logic                  memory_fault,
    output logic [7:0]            cfg_reg01,
    output ecl_pkg::ecl_cfg_t     cfg
);

    ecl_pkg::ecl_main_state_t state;

    logic        permit_s1, permit_s2, sda_s1, sda_s2;
    logic [3:0]  strap_s1, strap_s2;
    logic [3:0]  dev_idx;
    logic        go;
    logic [15:0] rd_addr;
    logic [15:0] tab_start;
    logic [5:0]  remain;
    logic [5:0]  bidx;
    logic [7:0]  hdr0, burst, exp_crc, crc;
    logic [7:0]  stage0, stage1, stage2;
    logic        eng_busy, eng_valid, eng_done, eng_fault;
    logic [7:0]  eng_data;

    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ({r[6:0], 1'b0} ^ ecl_pkg::CRC_POLY)
                     : {r[6:0], 1'b0};
        return r;
    endfunction : crc8

    // one decode serves single and multi-device images: the bit positions
    // of the first three block bytes agree in both layouts
    function automatic ecl_pkg::ecl_cfg_t decode(input logic [7:0] b0,
                                                 input logic [7:0] b1,
                                                 input logic [7:0] b2);
        ecl_pkg::ecl_cfg_t c;
        c = ecl_pkg::CFG_RESET;
        c.channel_b_power_down       = b0[1];
        c.channel_a_power_down       = b0[0];
        c.signal_absent_override     = b1[7];
        c.signal_absent_forced_value = b1[6];
        c.input_power_down           = b1[5];
        c.oscillator_power_down      = b1[4];
        c.ext_serial_ata_mode_a      = b1[2];
        c.ext_serial_ata_mode_b      = b1[1];
        c.transmit_off_override      = b1[0];
        c.transmit_off_a             = b2[7];
        c.transmit_off_b             = b2[6];
        c.fourth_boost_stage_b       = b2[4];
        c.fourth_boost_stage_a       = b2[3];
        c.quiet_threshold_override   = b2[1];
        return c;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    wire        fetching  = (state == ecl_pkg::M_HDR) ||
                            (state == ecl_pkg::M_TAB) ||
                            (state == ecl_pkg::M_DATA) ||
                            (state == ecl_pkg::M_CRCB);
    wire        cmd_go    = go && fetching && !eng_busy;
    // a zero burst size would stall the load, so it is taken as one
    wire [7:0]  burst_eff = (burst == 8'h00) ? 8'h01 : burst;
    wire [7:0]  cmd_len   = ({2'h0, remain} < burst_eff)
                            ? {2'h0, remain} : burst_eff;
    wire        cmd_wide  = (state != ecl_pkg::M_HDR) &&
                            hdr0[ecl_pkg::HDR_WIDE_BIT];
    wire        beyond    = dev_idx > hdr0[3:0];
    wire [15:0] tab_addr  = ecl_pkg::TABLE_BASE +
                            {11'h000, dev_idx, 1'b0};
    wire [15:0] map_free  = ecl_pkg::BLOCK_BASE +
                            16'({12'h000, dev_idx} *
                                {10'h000, ecl_pkg::DATA_LEN});
    wire        crc_ok    = !hdr0[ecl_pkg::HDR_CRC_EN_BIT] ||
                            (crc == exp_crc);

    ecl_twi_reader #(.QUARTER(QUARTER)) u_reader (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .cmd_go   (cmd_go),
        .cmd_addr (rd_addr),
        .cmd_wide (cmd_wide),
        .cmd_len  (cmd_len),
        .sda_sync (sda_s2),
        .busy     (eng_busy),
        .rx_valid (eng_valid),
        .rx_data  (eng_data),
        .done     (eng_done),
        .fault    (eng_fault),
        .scl_oe   (scl_oe),
        .sda_oe   (sda_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // pins are asynchronous; scl_in is not read since no clock stretching
    always_ff @(posedge core_clk) begin
        permit_s1 <= load_permit_n;
        permit_s2 <= permit_s1;
        sda_s1    <= sda_in;
        sda_s2    <= sda_s1;
        strap_s1  <= addr_strap;
        strap_s2  <= strap_s1;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state        <= ecl_pkg::M_WAIT;
            dev_idx      <= 4'h0;
            go           <= 1'b0;
            rd_addr      <= 16'h0000;
            tab_start    <= 16'h0000;
            remain       <= 6'h00;
            bidx         <= 6'h00;
            hdr0         <= 8'h00;
            burst        <= 8'h00;
            exp_crc      <= 8'h00;
            crc          <= ecl_pkg::CRC_INIT;
            stage0       <= 8'h00;
            stage1       <= 8'h00;
            stage2       <= 8'h00;
            scl_out      <= 1'b0;
            sda_out      <= 1'b0;
            load_done_n  <= 1'b1;
            load_busy    <= 1'b0;
            slave_mode   <= 1'b0;
            crc_fail     <= 1'b0;
            memory_fault <= 1'b0;
            cfg_reg01    <= ecl_pkg::REG01_RESET;
            cfg          <= ecl_pkg::CFG_RESET;
        end else begin
            if (cmd_go)
                go <= 1'b0;
            if (eng_valid) begin
                rd_addr <= rd_addr + 16'h0001;
                bidx    <= bidx + 6'h01;
                remain  <= remain - 6'h01;
                unique case (state)
                    ecl_pkg::M_HDR: begin
                        crc <= crc8(crc, eng_data);
                        if (bidx == 6'h00)
                            hdr0 <= eng_data;
                        if (bidx == ecl_pkg::HDR_IDX_BST)
                            burst <= eng_data;
                    end
                    ecl_pkg::M_TAB: begin
                        if (bidx == 6'h00)
                            exp_crc <= eng_data;
                        else
                            tab_start <= {8'h00, eng_data};
                    end
                    ecl_pkg::M_DATA: begin
                        crc <= crc8(crc, eng_data);
                        if (bidx == 6'h00)
                            stage0 <= eng_data;
                        if (bidx == 6'h01)
                            stage1 <= eng_data;
                        if (bidx == 6'h02)
                            stage2 <= eng_data;
                    end
                    default: exp_crc <= eng_data;
                endcase
            end
            unique case (state)
                ecl_pkg::M_WAIT: begin
                    if (!permit_s2) begin
                        dev_idx   <= strap_s2;
                        rd_addr   <= 16'h0000;
                        remain    <= ecl_pkg::HDR_LEN;
                        bidx      <= 6'h00;
                        go        <= 1'b1;
                        load_busy <= 1'b1;
                        state     <= ecl_pkg::M_HDR;
                    end
                end
                ecl_pkg::M_HDR, ecl_pkg::M_TAB,
                ecl_pkg::M_DATA, ecl_pkg::M_CRCB: begin
                    if (eng_done) begin
                        bidx <= 6'h00;
                        if (eng_fault) begin
                            memory_fault <= 1'b1;
                            state        <= ecl_pkg::M_DONE;
                        end else if (remain != 6'h00) begin
                            bidx <= bidx;
                            go   <= 1'b1;
                        end else if (state == ecl_pkg::M_HDR) begin
                            if (beyond) begin
                                state <= ecl_pkg::M_DONE;
                            end else if (hdr0[ecl_pkg::HDR_MAP_BIT]) begin
                                rd_addr <= tab_addr;
                                remain  <= 6'h02;
                                go      <= 1'b1;
                                state   <= ecl_pkg::M_TAB;
                            end else begin
                                rd_addr <= map_free;
                                remain  <= ecl_pkg::DATA_LEN;
                                go      <= 1'b1;
                                state   <= ecl_pkg::M_DATA;
                            end
                        end else if (state == ecl_pkg::M_TAB) begin
                            rd_addr <= tab_start;
                            remain  <= ecl_pkg::DATA_LEN;
                            go      <= 1'b1;
                            state   <= ecl_pkg::M_DATA;
                        end else if (state == ecl_pkg::M_DATA &&
                                     hdr0[ecl_pkg::HDR_CRC_EN_BIT] &&
                                     !hdr0[ecl_pkg::HDR_MAP_BIT]) begin
                            // without a table the crc sits after the block
                            remain <= 6'h01;
                            go     <= 1'b1;
                            state  <= ecl_pkg::M_CRCB;
                        end else begin
                            state <= ecl_pkg::M_CHECK;
                        end
                    end
                end
                ecl_pkg::M_CHECK: begin
                    // a bad image leaves the reset settings in place
                    if (crc_ok) begin
                        cfg_reg01 <= stage0;
                        cfg       <= decode(stage0, stage1, stage2);
                    end
                    crc_fail <= !crc_ok;
                    state    <= ecl_pkg::M_DONE;
                end
                ecl_pkg::M_DONE: begin
                    load_done_n <= 1'b0;
                    load_busy   <= 1'b0;
                    slave_mode  <= 1'b1;
                end
            endcase
        end
    end

endmodule : ecl_loader

/* test/ecl_mem_model.sv */
// ecl_mem_model: serial memory target at 0xA0/0xA1, byte-wide image
// assumes pull-ups on both lines; only the master drives the clock line
`timescale 1ns/1ps
module ecl_mem_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack_all,
    output logic      sda_oe
);
    logic [7:0] mem [0:255];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rd = 1'h0;
    logic       first = 1'h0;
    int         cnt = 0, run = 0, max_run = 0, total = 0;
    initial sda_oe = 1'h0;
    // a start or repeated start restarts framing and the burst count
    always @(negedge sda) if (scl) begin
        cnt = 0;
        first = 1'h1;
        rd = 1'h0;
        run = 0;
    end
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        if (cnt == 8 && rd && !sda_oe) begin
            ptr = ptr + 8'h01;
            run++;
            total++;
            if (run > max_run) max_run = run;
            rd = !sda; // master nack ends the read
        end
        cnt++;
    end
    // changes only with clock low
    always @(negedge scl) begin
        sda_oe = 1'h0;
        if (cnt == 9) cnt = 0;
        if (cnt == 8 && !rd && !nack_all && (!first || sh[7:1] == 7'h50)) begin
            sda_oe = 1'h1;
            if (first) rd = sh[0];
            else ptr = sh;
            first = 1'h0;
        end
        if (rd && cnt < 8) sda_oe = ~mem[ptr][7 - cnt];
    end
endmodule : ecl_mem_model

/* test/ecl_loader_chk.sv */
// ecl_loader_chk: port checks of the config image loader
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module ecl_loader_chk (
    input wire logic              core_clk,
    input wire logic              sys_rst,
    input wire logic              load_permit_n,
    input wire logic              scl_oe,
    input wire logic              sda_oe,
    input wire logic              load_done_n,
    input wire logic              load_busy,
    input wire logic              slave_mode,
    input wire logic              crc_fail,
    input wire logic              memory_fault,
    input wire logic [7:0]        cfg_reg01,
    input wire ecl_pkg::ecl_cfg_t cfg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    AST_PERMIT_FIRST: assert property (
        $rose(load_busy) |-> !$past(load_permit_n, 2))
        else $error("load began without permit");
    AST_DONE_FALL: assert property (
        $fell(load_done_n) |-> $past(load_busy) && !load_busy && slave_mode)
        else $error("done without end of load");
    AST_SLAVE_QUIET: assert property (
        slave_mode |-> !load_done_n && !load_busy && !scl_oe && !sda_oe)
        else $error("bus held in slave mode");
    AST_DONE_FINAL: assert property (
        !load_done_n |=> !load_done_n)
        else $error("done withdrawn");
    AST_BUS_QUIET_BEFORE: assert property (
        load_done_n && !load_busy |-> !scl_oe && !sda_oe)
        else $error("bus driven before load");
    AST_CFG_ONLY_IN_LOAD: assert property (
        !$stable({cfg, cfg_reg01}) |-> load_busy)
        else $error("settings changed outside load");
    AST_REJECT_KEEPS_RESET: assert property (
        crc_fail || memory_fault |-> cfg == ecl_pkg::CFG_RESET
            && cfg_reg01 == ecl_pkg::REG01_RESET)
        else $error("settings applied after reject");
    AST_CRC_AT_END: assert property (
        $rose(crc_fail) |-> load_busy)
        else $error("crc result outside load");
    cover property ($fell(load_done_n) && crc_fail);
    cover property ($fell(load_done_n) && memory_fault);
    cover property ($fell(load_done_n) && cfg_reg01 != 8'h00);
endmodule : ecl_loader_chk

/* test/testbench.sv */
// testbench: loads images from the memory model, checks the settings
// assumes pull-ups on both lines and a permit held low once given
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0] hdr0;
        logic [3:0] strap;
        logic [7:0] start;
        logic [4:0] flags; // nack, bad crc, applied, crc fail, fault
        logic [7:0] max_b;
        logic [7:0] total;
    } ecl_row_t;
    localparam logic [7:0] B0 = 8'hC6, B1 = 8'hA9, B2 = 8'h5A;
    localparam ecl_row_t ROWS [4] = '{
        '{8'h80, 4'h0, 8'h03, 5'h0A, 8'h20, 8'h29},
        '{8'hC3, 4'h5, 8'h0B, 5'h00, 8'h01, 8'h03},
        '{8'hC3, 4'h1, 8'h0B, 5'h11, 8'h00, 8'h00},
        '{8'hC3, 4'h1, 8'h0B, 5'h04, 8'h20, 8'h2A}};
    logic              core_clk = 1'h0, sys_rst = 1'h1;
    logic              load_permit_n = 1'h1, nack_all = 1'h0;
    logic [3:0]        addr_strap = 4'h0;
    logic              scl_out, scl_oe, sda_out, sda_oe, mem_oe;
    logic              load_done_n, load_busy, slave_mode;
    logic              crc_fail, memory_fault;
    logic [7:0]        cfg_reg01;
    ecl_pkg::ecl_cfg_t cfg;
    wire               scl = ~scl_oe;
    wire               sda = ~(sda_oe | mem_oe);
    int                n_mismatch = 0, checks_done = 0, cyc = 0;
    ecl_loader #(.QUARTER(4)) dut (.core_clk, .sys_rst, .load_permit_n,
        .addr_strap, .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe,
        .sda_out, .sda_oe, .load_done_n, .load_busy, .slave_mode,
        .crc_fail, .memory_fault, .cfg_reg01, .cfg);
    ecl_mem_model mdl (.scl, .sda, .nack_all, .sda_oe(mem_oe));
    ////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // reset per row, so each load starts cold
    task automatic restart(input ecl_row_t r);
        sys_rst = 1'h1;
        load_permit_n = 1'h1;
        addr_strap = r.strap;
        nack_all = r.flags[4];
        mdl.max_run = 0;
        mdl.total = 0;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'h0;
    endtask : restart
    task automatic run_row(input ecl_row_t r);
        logic [7:0] c, b;
        c = 8'h00;
        for (int a = 0; a < 256; a++) mdl.mem[a] = 8'hFF;
        for (int a = 0; a < 40; a++) begin
            b = a == 0 ? r.hdr0 : a == 1 ? 8'hFF : a == 2 ? 8'h20 :
                a == 3 ? B0 : a == 4 ? B1 : a == 5 ? B2 : 8'(a * 3);
            for (int i = 7; i >= 0; i--)
                c = {c[6:0], 1'h0} ^ ((c[7] ^ b[i]) ? ecl_pkg::CRC_POLY : 8'h00);
            mdl.mem[a < 3 ? a : r.start + a - 3] = b;
        end
        c = c ^ {8{r.flags[3]}};
        if (r.hdr0[6])
            for (int d = 0; d < 4; d++) begin
                mdl.mem[3 + 2 * d] = c;
                mdl.mem[4 + 2 * d] = r.start;
            end
        else
            mdl.mem[r.start + 37] = c;
        restart(r);
        load_permit_n = 1'h0;
        for (int w = 0; w < 20000 && load_done_n; w++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        check(load_done_n, 1'h0);
        check({slave_mode, scl_oe, sda_oe, scl_out, sda_out}, 5'h10);
        check(cfg_reg01, r.flags[2] ? B0 : 8'h00);
        check(cfg, r.flags[2] ? {B1[7:4], B1[2:0], B2[7:6], B2[4:3], B2[1],
            B0[1:0]} : 14'h0000);
        check({crc_fail, memory_fault}, r.flags[1:0]);
        check(mdl.max_run[7:0], r.max_b);
        check(mdl.total[7:0], r.total);
        $display("row with strap %0h done", r.strap);
    endtask : run_row
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        foreach (ROWS[k]) run_row(ROWS[k]);
        restart(ROWS[0]);
        repeat (300) @(negedge core_clk);
        check({load_busy, scl_oe, sda_oe, slave_mode}, 4'h0);
        check({load_done_n, cfg_reg01, cfg}, 23'h400000);
        $display("reset with permit held high done");
        results();
    end
endmodule : testbench
bind ecl_loader ecl_loader_chk chk (.core_clk, .sys_rst, .load_permit_n,
    .scl_oe, .sda_oe, .load_done_n, .load_busy, .slave_mode, .crc_fail,
    .memory_fault, .cfg_reg01, .cfg);
